// ---- bus_pad_pkg.sv ----
// constants for the external bus pad control block
package bus_pad_pkg;
  localparam int ADDR_W      = 23;  // whole external address bus
  localparam int ADDR_LOW_W  = 16;  // lines shared by program, data and i/o
  localparam int HOST_ADDR_W = 18;  // lines that turn to inputs in wide host mode
  localparam int DATA_W      = 16;  // external data bus width
  localparam int WB_ADR_W    = 4;   // wishbone byte address width

  // register byte offsets
  localparam logic [3:0] CTRL_OFS   = 4'h0;  // holder control
  localparam logic [3:0] STATUS_OFS = 4'h4;  // pad state readback

  // control register fields
  localparam int CTRL_DATA_HOLD_BIT = 0;     // data bus holder enable
  localparam logic CTRL_DATA_HOLD_RST = 1'b1; // holders on after reset

  // status register fields
  localparam int ST_ADDR_OE_BIT  = 0;
  localparam int ST_DATA_OE_BIT  = 1;
  localparam int ST_HOLD_BIT     = 2;
  localparam int ST_OFF_BIT      = 3;
  localparam int ST_WIDE_BIT     = 4;

  // address space targets from the core
  typedef enum logic [2:0] {
    SPACE_PROG = 3'b001,
    SPACE_DATA = 3'b010,
    SPACE_IO   = 3'b100
  } space_t;
endpackage

// ---- bus_holder.sv ----
// one bus-holder bank: keeps the last seen level of a set of pad lines
`timescale 1ns/1ns
module bus_holder #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  // pad view
  input  wire logic [W-1:0] line_in,    // level driven onto the wire
  input  wire logic         enable,     // holder may act
  input  wire logic         floating,   // nobody on our side drives
  output logic      [W-1:0] keep_out,   // level the holder keeps
  output logic              keep_oe     // holder drives weakly
);
  logic [W-1:0] last_r;    // last level captured
  logic [W-1:0] last_nxt;

  // capture only while the wire is driven, so the kept level is the last one
  always_comb begin
    last_nxt = last_r;
    if (!floating) begin
      last_nxt = line_in;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      last_r <= '0;
    end else begin
      last_r <= last_nxt;
    end
  end

  assign keep_out = last_r;
  assign keep_oe  = enable & floating;
endmodule

// ---- external_bus_pad_control.sv ----
// pad direction and enable control for the external address and data buses
`timescale 1ns/1ns
// Overview of operation
// - low sixteen address lines serve all spaces
// - upper seven lines only for program space
// - hold mode floats whole address bus
// - outputs-off low floats address bus
// - wide host mode makes low eighteen inputs
// - address holders keep last level when floating, not wide host lines or outputs-off
// - data bus carries core and host data
// - data floats when idle, reset or hold
// - outputs-off low floats data bus
// - enabled data holders keep last level unless outputs off
// - software enables data holders, not address
module external_bus_pad_control
  import bus_pad_pkg::*;
(
  // clock and reset
  input  wire logic                clk,
  input  wire logic                sys_rst,
  // wishbone slave
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [WB_ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  // core side request
  input  wire logic [ADDR_W-1:0]   core_addr,
  input  wire logic [2:0]          core_space,     // one-hot space_t
  input  wire logic                core_bus_act,   // external access in progress
  input  wire logic                core_data_wr,   // core writes data out
  input  wire logic [DATA_W-1:0]   core_wdata,
  output logic      [DATA_W-1:0]   core_rdata,
  output logic      [HOST_ADDR_W-1:0] host_addr,   // address from an external host
  input  wire logic                host_data_out,  // host port returns data
  input  wire logic [DATA_W-1:0]   host_rdata,
  // mode pins
  input  wire logic                hold_mode,      // hold granted
  input  wire logic                outputs_off_n,  // outputs-off pin, low floats
  input  wire logic                host_port_wide_mode_pin,
  input  wire logic                reset_pin_n,    // device reset pin, low active
  // external address bus pads
  input  wire logic [ADDR_W-1:0]   external_address_bus_i,
  output logic      [ADDR_W-1:0]   external_address_bus_o,
  output logic      [ADDR_W-1:0]   external_address_bus_oe,
  // external data bus pads
  input  wire logic [DATA_W-1:0]   external_data_bus_i,
  output logic      [DATA_W-1:0]   external_data_bus_o,
  output logic      [DATA_W-1:0]   external_data_bus_oe
);
  localparam int HI_W = ADDR_W - ADDR_LOW_W;  // program-only upper lines

  // register state
  logic              data_hold_en_r;    // software data holder switch
  logic              data_hold_en_nxt;
  logic              ack_r;             // wishbone answer
  logic              ack_nxt;
  logic [31:0]       rdat_r;            // wishbone read data
  logic [31:0]       rdat_nxt;
  // pad state
  logic [ADDR_W-1:0] a_o_r;
  logic [ADDR_W-1:0] a_o_nxt;
  logic [ADDR_W-1:0] a_oe_r;
  logic [ADDR_W-1:0] a_oe_nxt;
  logic [DATA_W-1:0] d_o_r;
  logic [DATA_W-1:0] d_o_nxt;
  logic [DATA_W-1:0] d_oe_r;
  logic [DATA_W-1:0] d_oe_nxt;
  logic [DATA_W-1:0] crd_r;             // data captured for the core
  logic [DATA_W-1:0] crd_nxt;
  logic [HOST_ADDR_W-1:0] hadr_r;       // host address captured
  logic [HOST_ADDR_W-1:0] hadr_nxt;
  // combinational helpers
  logic              addr_drive;        // address bus may be driven
  logic              data_drive;        // data bus driven on the next cycle
  logic              data_float;        // data bus left to others
  logic              prog_space;        // access targets program space
  logic [ADDR_W-1:0] addr_val;          // address value put on the pads
  logic [DATA_W-1:0] data_val;          // data value put on the pads
  logic [ADDR_W-1:0] a_keep;            // address holder level
  logic              a_keep_oe;
  logic [DATA_W-1:0] d_keep;            // data holder level
  logic              d_keep_oe;
  logic              wb_req;

  // address holders always on; software switch does not reach them
  bus_holder #(.W(ADDR_W)) u_addr_hold (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .line_in  (addr_val),                // level we put on the wire next
    .enable   (1'b1),
    .floating (~addr_drive),
    .keep_out (a_keep),
    .keep_oe  (a_keep_oe)
  );

  // data holders follow the control register bit
  bus_holder #(.W(DATA_W)) u_data_hold (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .line_in  (data_val),                // level we put on the wire next
    .enable   (data_hold_en_r),
    .floating (data_float),
    .keep_out (d_keep),
    .keep_oe  (d_keep_oe)
  );

  // drive decisions for both buses
  always_comb begin
    prog_space = core_space[0];
    // address goes out only outside hold, outputs-off and wide host mode
    addr_drive = !hold_mode && outputs_off_n && !host_port_wide_mode_pin;
    // data goes out only when something outputs, never in reset or hold
    data_drive = outputs_off_n && reset_pin_n && !hold_mode &&
                 ((core_bus_act && core_data_wr && !host_port_wide_mode_pin) ||
                  (host_port_wide_mode_pin && host_data_out));
    data_float = !data_drive;
    // low lines shared; upper lines only carry program addresses
    addr_val = '0;
    addr_val[ADDR_LOW_W-1:0] = core_addr[ADDR_LOW_W-1:0];
    if (prog_space) begin
      addr_val[ADDR_W-1:ADDR_LOW_W] = core_addr[ADDR_W-1:ADDR_LOW_W];
    end
    // data source: host port in wide mode, core otherwise
    data_val = host_port_wide_mode_pin ? host_rdata : core_wdata;
  end

  // next pad state
  always_comb begin
    a_o_nxt  = a_keep;
    a_oe_nxt = '0;
    if (addr_drive) begin
      a_o_nxt  = addr_val;
      a_oe_nxt = '1;
    end else if (a_keep_oe) begin
      // weak keeper: hold the last level on floated lines not owned by the host, none when outputs are off
      a_o_nxt  = a_keep;
      a_oe_nxt = '1;
      if (host_port_wide_mode_pin) begin
        // host drives the low lines, keep hands off them
        a_oe_nxt[HOST_ADDR_W-1:0] = '0;
      end
      if (!outputs_off_n) begin
        a_oe_nxt = '0;
      end
    end
    d_o_nxt  = d_keep;
    d_oe_nxt = '0;
    if (data_drive) begin
      d_o_nxt  = data_val;
      d_oe_nxt = '1;
    end else if (d_keep_oe && outputs_off_n) begin
      d_o_nxt  = d_keep;
      d_oe_nxt = '1;
    end
    // capture inbound data and host address
    crd_nxt  = crd_r;
    if (core_bus_act && !core_data_wr) begin
      crd_nxt = external_data_bus_i;
    end
    hadr_nxt = hadr_r;
    if (host_port_wide_mode_pin) begin
      hadr_nxt = external_address_bus_i[HOST_ADDR_W-1:0];
    end
  end

  // register all pads
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      a_o_r  <= '0;
      a_oe_r <= '0;
      d_o_r  <= '0;
      d_oe_r <= '0;
      crd_r  <= '0;
      hadr_r <= '0;
    end else begin
      a_o_r  <= a_o_nxt;
      a_oe_r <= a_oe_nxt;
      d_o_r  <= d_o_nxt;
      d_oe_r <= d_oe_nxt;
      crd_r  <= crd_nxt;
      hadr_r <= hadr_nxt;
    end
  end

  // wishbone slave: one wait state, ack dropped the cycle after
  always_comb begin
    wb_req           = wb_cyc_i && wb_stb_i && !ack_r;
    ack_nxt          = wb_req;
    rdat_nxt         = rdat_r;
    data_hold_en_nxt = data_hold_en_r;
    if (wb_req) begin
      rdat_nxt = '0;
      unique case (wb_adr_i)
        CTRL_OFS: begin
          rdat_nxt[CTRL_DATA_HOLD_BIT] = data_hold_en_r;
        end
        STATUS_OFS: begin
          rdat_nxt[ST_ADDR_OE_BIT] = addr_drive;
          rdat_nxt[ST_DATA_OE_BIT] = data_drive;
          rdat_nxt[ST_HOLD_BIT]    = hold_mode;
          rdat_nxt[ST_OFF_BIT]     = !outputs_off_n;
          rdat_nxt[ST_WIDE_BIT]    = host_port_wide_mode_pin;
        end
        default: begin
          rdat_nxt = '0;  // unmapped reads zero, writes ignored
        end
      endcase
    end
    // a write lands at the edge where the master sees ack, not before
    if (wb_cyc_i && wb_stb_i && ack_r && wb_we_i && wb_sel_i[0] &&
        (wb_adr_i == CTRL_OFS)) begin
      data_hold_en_nxt = wb_dat_i[CTRL_DATA_HOLD_BIT];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      data_hold_en_r <= CTRL_DATA_HOLD_RST;
      ack_r          <= 1'b0;
      rdat_r         <= '0;
    end else begin
      data_hold_en_r <= data_hold_en_nxt;
      ack_r          <= ack_nxt;
      rdat_r         <= rdat_nxt;
    end
  end

  // outputs straight from flip-flops
  assign wb_ack_o                = ack_r;
  assign wb_dat_o                = rdat_r;
  assign external_address_bus_o  = a_o_r;
  assign external_address_bus_oe = a_oe_r;
  assign external_data_bus_o     = d_o_r;
  assign external_data_bus_oe    = d_oe_r;
  assign core_rdata              = crd_r;
  assign host_addr               = hadr_r;
endmodule

// ---- bus_pad_monitor.sv ----
// port assertions for the external bus pad control block
`timescale 1ns/1ns
module bus_pad_monitor
  import bus_pad_pkg::*;
(
  // clock, reset and bus handshake
  input wire logic clk, sys_rst, wb_cyc_i, wb_stb_i, wb_ack_o,
  // core request and mode pins
  input wire logic [ADDR_W-1:0] core_addr,
  input wire logic [2:0] core_space,
  input wire logic core_bus_act, core_data_wr, hold_mode, outputs_off_n,
  input wire logic host_port_wide_mode_pin, reset_pin_n,
  input wire logic [DATA_W-1:0] core_wdata,
  // pads
  input wire logic [HOST_ADDR_W-1:0] host_addr,
  input wire logic [ADDR_W-1:0] external_address_bus_i, external_address_bus_o,
  input wire logic [ADDR_W-1:0] external_address_bus_oe,
  input wire logic [DATA_W-1:0] external_data_bus_o, external_data_bus_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // address may be driven by us
  wire a_drv = !hold_mode && outputs_off_n && !host_port_wide_mode_pin;
  // core write may be driven
  wire d_wr = a_drv && reset_pin_n && core_bus_act && core_data_wr;
  chk_addr_drive: assert property (!$past(sys_rst) && $past(a_drv) |->
    external_address_bus_oe == '1
    && external_address_bus_o[15:0] == $past(core_addr[15:0])) else $error("addr drive");
  chk_addr_upper: assert property (!$past(sys_rst) && $past(a_drv) |->
    external_address_bus_o[22:16] ==
    ($past(core_space[0]) ? $past(core_addr[22:16]) : 7'h00)) else $error("addr upper");
  chk_addr_off: assert property (!$past(outputs_off_n) |-> external_address_bus_oe == '0)
    else $error("addr not off");
  chk_wide_inputs: assert property ($past(host_port_wide_mode_pin)
    |-> external_address_bus_oe[17:0] == 18'h00000) else $error("wide lines driven");
  chk_host_addr: assert property ($past(host_port_wide_mode_pin) && !$past(sys_rst)
    |-> host_addr == $past(external_address_bus_i[17:0])) else $error("host addr");
  chk_addr_keep: assert property (!$past(sys_rst) && $past(external_address_bus_oe) == '1
    && $past(hold_mode && outputs_off_n && !host_port_wide_mode_pin)
    |-> external_address_bus_o == $past(external_address_bus_o)) else $error("addr keep");
  chk_data_off: assert property (!$past(outputs_off_n) |-> external_data_bus_oe == '0)
    else $error("data not off");
  chk_data_write: assert property ($past(d_wr) |-> external_data_bus_oe == '1
    && external_data_bus_o == $past(core_wdata)) else $error("data write");
  chk_data_float: assert property (!$past(sys_rst) && $past(hold_mode || !reset_pin_n)
    && $past(external_data_bus_oe) == '1 |-> external_data_bus_o ==
    $past(external_data_bus_o)) else $error("data float");
  chk_ack_pulse: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack pulse");
  cover property ($past(hold_mode) && external_address_bus_oe == '1);
  cover property ($past(host_port_wide_mode_pin));
  cover property ($past(d_wr));
endmodule

// ---- bus_far_model.sv ----
// far side of the pads: memory returning data and a host driving addresses
`timescale 1ns/1ns
module bus_far_model
  import bus_pad_pkg::*;
(
  // clock
  input  wire logic                   clk,
  // device pads
  input  wire logic [ADDR_W-1:0]      a_o,
  input  wire logic [ADDR_W-1:0]      a_oe,
  input  wire logic [DATA_W-1:0]      d_o,
  input  wire logic [DATA_W-1:0]      d_oe,
  // far side requests
  input  wire logic                   host_drv,
  input  wire logic [HOST_ADDR_W-1:0] host_val,
  input  wire logic                   mem_drv,
  input  wire logic [DATA_W-1:0]      mem_val,
  // resolved wire levels
  output logic      [ADDR_W-1:0]      a_i,
  output logic      [DATA_W-1:0]      d_i
);
  logic [ADDR_W-1:0] a_last = '0;  // last level, inverted when nobody drives
  logic [DATA_W-1:0] d_last = '0;
  logic [ADDR_W-1:0] a_far;   // far side address level
  // device address bits win, released ones toggle unless the host drives them; a driving memory wins the data bus
  always_comb begin
    a_far = ~a_last;
    if (host_drv) a_far[HOST_ADDR_W-1:0] = host_val;
    a_i = (a_oe & a_o) | (~a_oe & a_far);
    // a driving memory overpowers the weak holder on the device side
    d_i = mem_drv ? mem_val : ((d_oe & d_o) | (~d_oe & ~d_last));
  end
  // remember the wire
  always @(posedge clk) begin
    a_last <= a_i;
    d_last <= d_i;
  end
endmodule

// ---- tb_top.sv ----
// self-checking bench for the pad control block
`timescale 1ns/1ns
module tb_top;
  import bus_pad_pkg::*;
  logic clk, sys_rst, cyc, stb, we, ack, act, wr, hdo, hold, offn, wide, rpn, mdrv;
  logic [3:0] adr;
  logic [31:0] wdat, rdat, got, r;
  logic [ADDR_W-1:0] caddr, a_i, a_o, a_oe;
  logic [DATA_W-1:0] cw, crd, hrd, d_i, d_o, d_oe, mval;
  logic [2:0] sp;
  logic [HOST_ADDR_W-1:0] haddr, hval;
  int failures, total_checks;
  logic [31:0] seed = 32'h00000057;
  external_bus_pad_control u_external_bus_pad_control (.clk, .sys_rst, .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .core_addr(caddr), .core_space(sp), .core_bus_act(act),
    .core_data_wr(wr), .core_wdata(cw), .core_rdata(crd), .host_addr(haddr),
    .host_data_out(hdo), .host_rdata(hrd), .hold_mode(hold), .outputs_off_n(offn),
    .host_port_wide_mode_pin(wide), .reset_pin_n(rpn), .external_address_bus_i(a_i),
    .external_address_bus_o(a_o), .external_address_bus_oe(a_oe),
    .external_data_bus_i(d_i), .external_data_bus_o(d_o), .external_data_bus_oe(d_oe));
  bus_far_model u_bus_far_model (.clk, .a_o, .a_oe, .d_o, .d_oe, .host_drv(wide),
    .host_val(hval), .mem_drv(mdrv), .mem_val(mval), .a_i, .d_i);
  // xorshift source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // expected address lines while driven
  function automatic logic [31:0] exp_a(logic [ADDR_W-1:0] a, logic [2:0] s);
    return s[0] ? {9'h000, a} : {16'h0000, a[15:0]};
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // one classic wishbone cycle
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    do @(posedge clk); while (ack !== 1'b1);
    got = rdat;
    {cyc, stb} <= 2'b00;
  endtask
  task automatic stop_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // watchdog
  initial begin
    #100000;
    failures++;
    stop_test();
  end
  initial begin
    sys_rst = 1'b1;
    {cyc, stb, we, adr, wdat, act, wr, hdo, hold, wide, mdrv} = '0;
    {offn, rpn, caddr, cw, hrd, mval, sp, hval} = {2'b11, 92'h0};
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    wb(1'b0, CTRL_OFS, 32'h0);
    chk(got, 32'h1);
    wb(1'b0, 4'h8, 32'h0);
    chk(got, 32'h0);
    $display("registers done");
    repeat (300) begin
      @(posedge clk);
      r = rnd();
      {hold, offn, wide, rpn, act, wr, hdo} <= {&r[1:0], |r[3:2], &r[5:4], |r[7:6], r[10:8]};
      {caddr, cw, hval, hrd} <= {r[31:9], r[27:12], r[29:12], r[15:0]};
      sp <= 3'h1 << (r[11:10] % 2'h3);
      @(posedge clk);
      #1;
      if (!hold && offn && !wide) begin
        chk(a_oe, 32'h7fffff);
        chk(a_o, exp_a(caddr, sp));
      end
      if (offn && rpn && !hold && act && wr && !wide)
        chk(d_o, cw);
      if (offn && rpn && !hold && wide && hdo)
        chk(d_o, hrd);
      if (!offn) begin
        chk(a_oe, 32'h0);
        chk(d_oe, 32'h0);
      end
      if (wide)
        chk(a_oe[17:0], 32'h0);
    end
    $display("random done");
    {hold, offn, wide, rpn, act, wr, mdrv, mval} <= {7'h2d, 16'h5aa5};
    repeat (3) @(posedge clk);
    chk(crd, 32'h5aa5);
    wb(1'b1, CTRL_OFS, 32'h0);
    {act, mdrv, hold} <= 3'b001;
    repeat (2) @(posedge clk);
    #1;
    chk(d_oe, 32'h0);
    chk(a_oe, 32'h7fffff);
    wb(1'b1, CTRL_OFS, 32'h1);
    {hold, act, wr, cw} <= {3'b011, 16'hc3e1};
    repeat (2) @(posedge clk);
    {act, rpn} <= 2'b00;
    repeat (2) @(posedge clk);
    #1;
    chk(d_oe, 32'hffff);
    chk(d_o, 32'hc3e1);
    $display("holders done");
    stop_test();
  end
endmodule
bind external_bus_pad_control bus_pad_monitor u_bus_pad_monitor (.clk, .sys_rst, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .core_addr, .core_space, .core_bus_act, .core_data_wr, .hold_mode,
  .outputs_off_n, .host_port_wide_mode_pin, .reset_pin_n, .core_wdata, .host_addr,
  .external_address_bus_i, .external_address_bus_o, .external_address_bus_oe,
  .external_data_bus_o, .external_data_bus_oe);
